// ==== design/tlic_regs.svh ====
/*
  addresses, reset values, fields, polling order and vectors.
  assumes inclusion by bare name from the package and the modules.
*/
`ifndef TLIC_REGS_SVH
`define TLIC_REGS_SVH

// ====
// special register addresses
`define TLIC_ADDR_PRIMARY_ENABLE   8'ha8
`define TLIC_ADDR_SECONDARY        8'ha9
`define TLIC_ADDR_PRIMARY_LEVEL    8'hb8

// ====
// reset values
`define TLIC_RST_PRIMARY_ENABLE    8'h00
`define TLIC_RST_SECONDARY         8'ha0
`define TLIC_RST_PRIMARY_LEVEL     8'h00
`define TLIC_RDATA_UNMAPPED        8'h00

// ====
// field positions, primary enable and primary level
`define TLIC_BIT_GLOBAL_ENABLE     7
`define TLIC_BIT_ADC               6
`define TLIC_BIT_TIMER2            5
`define TLIC_BIT_UART              4
`define TLIC_BIT_TIMER1            3
`define TLIC_BIT_EXT1              2
`define TLIC_BIT_TIMER0            1
`define TLIC_BIT_EXT0              0
`define TLIC_BIT_LEVEL_RSVD        7

// ====
// field positions, secondary enable and level register
`define TLIC_BIT_TIC_LEVEL         6
`define TLIC_BIT_PSM_LEVEL         5
`define TLIC_BIT_SERIAL_LEVEL      4
`define TLIC_BIT_SEC_RSVD          3
`define TLIC_BIT_TIC_ENABLE        2
`define TLIC_BIT_PSM_ENABLE        1
`define TLIC_BIT_SERIAL_ENABLE     0

// ====
// source index in polling order, 0 is polled first
`define TLIC_SRC_COUNT             11
`define TLIC_SRC_PSM               4'h0
`define TLIC_SRC_WDT               4'h1
`define TLIC_SRC_EXT0              4'h2
`define TLIC_SRC_ADC               4'h3
`define TLIC_SRC_TIMER0            4'h4
`define TLIC_SRC_EXT1              4'h5
`define TLIC_SRC_TIMER1            4'h6
`define TLIC_SRC_SERIAL            4'h7
`define TLIC_SRC_UART              4'h8
`define TLIC_SRC_TIMER2            4'h9
`define TLIC_SRC_TIC               4'ha

// ====
// vector addresses
`define TLIC_VEC_EXT0              16'h0003
`define TLIC_VEC_TIMER0            16'h000b
`define TLIC_VEC_EXT1              16'h0013
`define TLIC_VEC_TIMER1            16'h001b
`define TLIC_VEC_UART              16'h0023
`define TLIC_VEC_TIMER2            16'h002b
`define TLIC_VEC_ADC               16'h0033
`define TLIC_VEC_SERIAL            16'h003b
`define TLIC_VEC_PSM               16'h0043
`define TLIC_VEC_TIC               16'h0053
`define TLIC_VEC_WDT               16'h005b
`define TLIC_VEC_NONE              16'h0000

`endif

// ==== design/tlic_pkg.sv ====
/*
  types of the two level interrupt controller.
  assumes tlic_regs.svh is on the include path.
*/
package tlic_pkg;
  `include "tlic_regs.svh"

  // ====
  // vectoring sequencer states
  typedef enum logic [1:0]
  {
    TLIC_IDLE = 2'b00,   // waiting for an eligible request
    TLIC_PUSH = 2'b01,   // core pushes the program counter
    TLIC_LOAD = 2'b10    // core loads the vector
  } tlic_state_t;

  typedef logic [3:0]                 tlic_src_t;   // source index
  typedef logic [`TLIC_SRC_COUNT-1:0] tlic_vec_t;   // one bit per source
  typedef logic [15:0]                tlic_addr_t;  // code address
endpackage

// ==== design/tlic_first_pick.sv ====
/*
  fixed order picker: returns the lowest index set in a request vector.
  assumes index 0 is the source polled first.
*/
`include "tlic_regs.svh"
module tlic_first_pick
  import tlic_pkg::*;
(
  // requests
  input  wire tlic_vec_t req_i,
  // result
  output logic           valid_o,
  output tlic_src_t      index_o
);

  // ====
  // priority chain
  tlic_vec_t           seen;               // some lower index already set
  tlic_vec_t           sel;                // one hot winner
  tlic_src_t           idx_acc [0:`TLIC_SRC_COUNT];  // or of winner index

  assign idx_acc[0] = 4'h0;

  genvar i;
  generate
    for (i = 0; i < `TLIC_SRC_COUNT; i = i + 1)
    begin : g_chain
      if (i == 0)
      begin : g_first
        assign seen[i] = 1'b0;
      end
      else
      begin : g_rest
        assign seen[i] = seen[i-1] | req_i[i-1];
      end
      // winner is the first set bit
      assign sel[i]       = req_i[i] & ~seen[i];
      assign idx_acc[i+1] = idx_acc[i] | (sel[i] ? 4'(i) : 4'h0);
    end
  endgenerate

  assign valid_o = |req_i;
  assign index_o = idx_acc[`TLIC_SRC_COUNT];

endmodule // tlic_first_pick

// ==== design/tlic_top.sv ====
/*
  two level interrupt controller for an 8-bit core, eleven sources:
  registers, arbitration, then a push and a vector load to the core.
  assumes one clock, a synchronous register port, held flag levels.
*/
// Behaviour
// R1 - primary level register: seven source level bits
// R2 - secondary register level bits at 6,5,4
// R3 - secondary register enable bits at 2,1,0
// R4 - software writes zero to secondary bit 3
// R5 - secondary register at a9h, resets a0h
// R6 - high level preempts running low routine
// R7 - simultaneous levels: high serviced first
// R8 - same level never preempts running routine
// R9 - same level resolved by fixed polling order
// R10 - push program counter, then load vector
// R11 - each source has its fixed vector address
// R12 - watchdog interrupts when select bit set
// R13 - watchdog is always high level
// R14 - global disable never masks the watchdog
// R15 - watchdog interrupts only with nonzero timeout
// R16 - per source enable, one of two levels
// R17 - primary bit 7 is the global enable
// R18 - primary enable register per source bits
// R19 - return drops most recent active level
`include "tlic_regs.svh"
module tlic_top
  import tlic_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  // special register port of the core
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_rd_i,
  output logic            sfr_hit_o,
  output logic      [7:0] sfr_rdata_o,
  // peripheral request flags
  input  wire logic       ext0_request_flag_i,
  input  wire logic       ext1_request_flag_i,
  input  wire logic       timer0_overflow_flag_i,
  input  wire logic       timer1_overflow_flag_i,
  input  wire logic       timer2_overflow_flag_i,
  input  wire logic       timer2_external_flag_i,
  input  wire logic       uart_receive_flag_i,
  input  wire logic       uart_send_flag_i,
  input  wire logic       primary_adc_ready_i,
  input  wire logic       aux_adc_ready_i,
  input  wire logic       spi_irq_flag_i,
  input  wire logic       two_wire_irq_flag_i,
  input  wire logic       supply_monitor_irq_flag_i,
  input  wire logic       interval_timer_irq_flag_i,
  // watchdog
  input  wire logic       watchdog_irq_flag_i,
  input  wire logic       watchdog_irq_select_i,
  input  wire logic [3:0] watchdog_timeout_i,
  // core fetch and stack handshake
  input  wire logic       core_boundary_i,
  input  wire logic       core_reti_i,
  output logic            irq_pending_o,
  output logic            stack_push_o,
  output logic            vector_load_o,
  output logic     [15:0] vector_o,
  output logic      [3:0] source_o,
  output logic      [1:0] active_levels_o
);

  // ====
  // registers
  logic [7:0]  primary_enable_reg;          // global and per source enables
  logic [7:0]  primary_level_reg;           // per source level bits
  logic [7:0]  secondary_enable_level_reg;  // extra sources enable and level

  // ====
  // register decode
  wire         hit_enable;                  // primary enable addressed
  wire         hit_level;                   // primary level addressed
  wire         hit_secondary;               // secondary register addressed
  logic [7:0]  read_mux;                    // value of addressed register

  assign hit_enable    = (sfr_addr_i == `TLIC_ADDR_PRIMARY_ENABLE);
  assign hit_level     = (sfr_addr_i == `TLIC_ADDR_PRIMARY_LEVEL);
  assign hit_secondary = (sfr_addr_i == `TLIC_ADDR_SECONDARY);  // R5
  assign sfr_hit_o     = hit_enable | hit_level | hit_secondary;

  // read selection, unmapped addresses read zero
  always_comb
  begin
    if (hit_enable)
      read_mux = primary_enable_reg;                             // R18
    else if (hit_level)
      read_mux = primary_level_reg;                              // R1
    else if (hit_secondary)
      read_mux = secondary_enable_level_reg;                     // R2
    else
      read_mux = `TLIC_RDATA_UNMAPPED;
  end

  // ====
  // register writes
  // no bit address: bit operations come as read-modify-write
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      primary_enable_reg         <= `TLIC_RST_PRIMARY_ENABLE;
      primary_level_reg          <= `TLIC_RST_PRIMARY_LEVEL;
      secondary_enable_level_reg <= `TLIC_RST_SECONDARY;         // R5
    end
    else if (sfr_wr_i)
    begin
      // global enable and seven source enables
      if (hit_enable)
        primary_enable_reg <= sfr_wdata_i;                       // R17
      // reserved top bit of the level register stays zero
      if (hit_level)
        primary_level_reg <= {1'b0, sfr_wdata_i[6:0]};           // R1
      // bit 3 is kept as written; software keeps it zero
      if (hit_secondary)
        secondary_enable_level_reg <= sfr_wdata_i;               // R3
    end
  end

  // read data, captured on the read strobe and held
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      sfr_rdata_o <= `TLIC_RDATA_UNMAPPED;
    else if (sfr_rd_i)
      sfr_rdata_o <= read_mux;
  end

  // ====
  // raw source requests in polling order
  wire         global_enable;               // master enable bit
  wire         watchdog_armed;              // interrupt mode, nonzero timeout
  tlic_vec_t   raw_req;                     // combined peripheral flags
  tlic_vec_t   src_enable;                  // per source enable
  tlic_vec_t   src_level;                   // per source level, 1 is high
  tlic_vec_t   eligible;                    // enabled requests

  assign global_enable  = primary_enable_reg[`TLIC_BIT_GLOBAL_ENABLE];  // R17
  assign watchdog_armed = watchdog_irq_select_i                         // R12
                          & (watchdog_timeout_i != 4'h0);               // R15

  // paired flags of one source share a request
  assign raw_req[`TLIC_SRC_PSM]    = supply_monitor_irq_flag_i;
  assign raw_req[`TLIC_SRC_WDT]    = watchdog_irq_flag_i & watchdog_armed;  // R12
  assign raw_req[`TLIC_SRC_EXT0]   = ext0_request_flag_i;
  assign raw_req[`TLIC_SRC_ADC]    = primary_adc_ready_i | aux_adc_ready_i;
  assign raw_req[`TLIC_SRC_TIMER0] = timer0_overflow_flag_i;
  assign raw_req[`TLIC_SRC_EXT1]   = ext1_request_flag_i;
  assign raw_req[`TLIC_SRC_TIMER1] = timer1_overflow_flag_i;
  assign raw_req[`TLIC_SRC_SERIAL] = spi_irq_flag_i | two_wire_irq_flag_i;
  assign raw_req[`TLIC_SRC_UART]   = uart_receive_flag_i | uart_send_flag_i;
  assign raw_req[`TLIC_SRC_TIMER2] = timer2_overflow_flag_i | timer2_external_flag_i;
  assign raw_req[`TLIC_SRC_TIC]    = interval_timer_irq_flag_i;

  // ====
  // per source enables
  // watchdog has no enable bit and ignores the global enable
  assign src_enable[`TLIC_SRC_PSM]    =
    secondary_enable_level_reg[`TLIC_BIT_PSM_ENABLE];            // R3
  assign src_enable[`TLIC_SRC_WDT]    = 1'b1;                    // R14
  assign src_enable[`TLIC_SRC_EXT0]   = primary_enable_reg[`TLIC_BIT_EXT0];    // R18
  assign src_enable[`TLIC_SRC_ADC]    = primary_enable_reg[`TLIC_BIT_ADC];
  assign src_enable[`TLIC_SRC_TIMER0] = primary_enable_reg[`TLIC_BIT_TIMER0];
  assign src_enable[`TLIC_SRC_EXT1]   = primary_enable_reg[`TLIC_BIT_EXT1];
  assign src_enable[`TLIC_SRC_TIMER1] = primary_enable_reg[`TLIC_BIT_TIMER1];
  assign src_enable[`TLIC_SRC_SERIAL] =
    secondary_enable_level_reg[`TLIC_BIT_SERIAL_ENABLE];         // R3
  assign src_enable[`TLIC_SRC_UART]   = primary_enable_reg[`TLIC_BIT_UART];
  assign src_enable[`TLIC_SRC_TIMER2] = primary_enable_reg[`TLIC_BIT_TIMER2];
  assign src_enable[`TLIC_SRC_TIC]    =
    secondary_enable_level_reg[`TLIC_BIT_TIC_ENABLE];            // R3

  // ====
  // per source levels
  assign src_level[`TLIC_SRC_PSM]    =
    secondary_enable_level_reg[`TLIC_BIT_PSM_LEVEL];             // R2
  assign src_level[`TLIC_SRC_WDT]    = 1'b1;                     // R13
  assign src_level[`TLIC_SRC_EXT0]   = primary_level_reg[`TLIC_BIT_EXT0];      // R1
  assign src_level[`TLIC_SRC_ADC]    = primary_level_reg[`TLIC_BIT_ADC];
  assign src_level[`TLIC_SRC_TIMER0] = primary_level_reg[`TLIC_BIT_TIMER0];
  assign src_level[`TLIC_SRC_EXT1]   = primary_level_reg[`TLIC_BIT_EXT1];
  assign src_level[`TLIC_SRC_TIMER1] = primary_level_reg[`TLIC_BIT_TIMER1];
  assign src_level[`TLIC_SRC_SERIAL] =
    secondary_enable_level_reg[`TLIC_BIT_SERIAL_LEVEL];          // R2
  assign src_level[`TLIC_SRC_UART]   = primary_level_reg[`TLIC_BIT_UART];
  assign src_level[`TLIC_SRC_TIMER2] = primary_level_reg[`TLIC_BIT_TIMER2];
  assign src_level[`TLIC_SRC_TIC]    =
    secondary_enable_level_reg[`TLIC_BIT_TIC_LEVEL];             // R2

  // ====
  // gating: per source enable, then global enable except watchdog
  tlic_vec_t   global_gate;                 // global enable per source

  assign global_gate = {`TLIC_SRC_COUNT{global_enable}}
                       | (tlic_vec_t'(1) << `TLIC_SRC_WDT);      // R14
  assign eligible    = raw_req & src_enable & global_gate;       // R16

  // ====
  // level split and arbitration
  logic        active_high;                 // high level routine running
  logic        active_low;                  // low level routine running
  tlic_vec_t   high_req;                    // eligible high level requests
  tlic_vec_t   low_req;                     // eligible low level requests
  wire         high_valid;                  // some high request
  wire         low_valid;                   // some low request
  tlic_src_t   high_index;                  // first high request
  tlic_src_t   low_index;                   // first low request
  wire         high_allowed;                // high may be taken now
  wire         low_allowed;                 // low may be taken now
  wire         take_high;                   // high wins this cycle
  wire         take_low;                    // low wins this cycle
  wire         winner_valid;                // something may be vectored
  tlic_src_t   winner_index;                // chosen source

  assign high_req = eligible & src_level;                        // R16
  assign low_req  = eligible & ~src_level;

  // fixed polling order within each level
  tlic_first_pick u_pick_high
  (
    .req_i   (high_req),
    .valid_o (high_valid),
    .index_o (high_index)                                        // R9
  );

  tlic_first_pick u_pick_low
  (
    .req_i   (low_req),
    .valid_o (low_valid),
    .index_o (low_index)                                         // R9
  );

  // high preempts low, nothing preempts its own level
  assign high_allowed = ~active_high;                            // R6
  assign low_allowed  = ~active_high & ~active_low;              // R8
  assign take_high    = high_valid & high_allowed;               // R7
  assign take_low     = low_valid & low_allowed & ~take_high;    // R7
  assign winner_valid = take_high | take_low;
  assign winner_index = take_high ? high_index : low_index;

  // ====
  // vector lookup
  tlic_addr_t  winner_vector;               // vector of the chosen source

  always_comb
  begin
    case (winner_index)
      `TLIC_SRC_EXT0:   winner_vector = `TLIC_VEC_EXT0;          // R11
      `TLIC_SRC_TIMER0: winner_vector = `TLIC_VEC_TIMER0;
      `TLIC_SRC_EXT1:   winner_vector = `TLIC_VEC_EXT1;
      `TLIC_SRC_TIMER1: winner_vector = `TLIC_VEC_TIMER1;
      `TLIC_SRC_UART:   winner_vector = `TLIC_VEC_UART;
      `TLIC_SRC_TIMER2: winner_vector = `TLIC_VEC_TIMER2;
      `TLIC_SRC_ADC:    winner_vector = `TLIC_VEC_ADC;
      `TLIC_SRC_SERIAL: winner_vector = `TLIC_VEC_SERIAL;
      `TLIC_SRC_PSM:    winner_vector = `TLIC_VEC_PSM;
      `TLIC_SRC_TIC:    winner_vector = `TLIC_VEC_TIC;
      `TLIC_SRC_WDT:    winner_vector = `TLIC_VEC_WDT;
      default:          winner_vector = `TLIC_VEC_NONE;
    endcase
  end

  // ====
  // vectoring sequencer
  tlic_state_t state;                       // current step
  tlic_state_t next_state;                  // step for next edge
  wire         accept;                      // request taken this cycle

  // only at an instruction boundary while idle
  assign accept = (state == TLIC_IDLE) & core_boundary_i & winner_valid;

  // push first, load the vector one cycle later
  always_comb
  begin
    next_state = state;
    case (state)
      TLIC_IDLE:
        if (accept)
          next_state = TLIC_PUSH;                                // R10
      TLIC_PUSH:
        next_state = TLIC_LOAD;                                  // R10
      TLIC_LOAD:
        next_state = TLIC_IDLE;
      default:
        next_state = TLIC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= TLIC_IDLE;
    else
      state <= next_state;
  end

  // strobes to the core follow the state
  assign stack_push_o  = (state == TLIC_PUSH);                   // R10
  assign vector_load_o = (state == TLIC_LOAD);                   // R10
  assign irq_pending_o = winner_valid;

  // ====
  // vector and source latched at acceptance
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      vector_o <= `TLIC_VEC_NONE;
      source_o <= 4'h0;
    end
    else if (accept)
    begin
      vector_o <= winner_vector;                                 // R11
      source_o <= winner_index;
    end
  end

  // ====
  // active level tracking
  // a return drops the most recent level: high nests above low.
  // an accept in the same cycle as a return wins over its clear
  logic        next_active_high;            // high level after this edge
  logic        next_active_low;             // low level after this edge

  always_comb
  begin
    next_active_high = active_high;
    next_active_low  = active_low;
    if (core_reti_i)
    begin
      if (active_high)
        next_active_high = 1'b0;                                 // R19
      else
        next_active_low = 1'b0;                                  // R19
    end
    if (accept)
    begin
      if (take_high)
        next_active_high = 1'b1;                                 // R6
      else
        next_active_low = 1'b1;                                  // R8
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      active_high <= 1'b0;
      active_low  <= 1'b0;
    end
    else
    begin
      active_high <= next_active_high;
      active_low  <= next_active_low;
    end
  end

  assign active_levels_o = {active_high, active_low};

endmodule // tlic_top

// ==== dv/tlic_properties.sv ====
/*
  port checker of the interrupt controller.
  assumes it is bound to tlic_top and sees only its ports.
*/
module tlic_properties
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // watchdog
  input  wire logic        watchdog_irq_flag_i,
  input  wire logic        watchdog_irq_select_i,
  input  wire logic [3:0]  watchdog_timeout_i,
  // core handshake
  input  wire logic        core_boundary_i,
  input  wire logic        core_reti_i,
  input  wire logic        irq_pending_o,
  input  wire logic        stack_push_o,
  input  wire logic        vector_load_o,
  input  wire logic [15:0] vector_o,
  input  wire logic [3:0]  source_o,
  input  wire logic [1:0]  active_levels_o
);
  // ====
  // vector of each source, in polling order
  localparam logic [15:0] VEC [11] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b,
    16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
  logic wdt_live;  // watchdog request that must be seen
  assign wdt_live = watchdog_irq_flag_i && watchdog_irq_select_i && watchdog_timeout_i != 4'h0;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // acceptance in idle, then push then load
  sequence accept_s;
    core_boundary_i && irq_pending_o && !stack_push_o && !vector_load_o;
  endsequence
  sequence entry_s;
    stack_push_o ##1 vector_load_o;
  endsequence
  AST_ACCEPT: assert property (accept_s |=> entry_s)
    else $error("no push then load");
  AST_PUSH_ONE: assert property (stack_push_o |=> !stack_push_o ##1 !stack_push_o)
    else $error("push repeated too soon");
  AST_VEC: assert property (vector_load_o |-> vector_o == VEC[source_o])
    else $error("wrong vector");
  AST_WDT_HIGH: assert property (stack_push_o && source_o == 4'h1 |-> active_levels_o[1])
    else $error("watchdog not high level");
  AST_WDT_BYPASS: assert property (wdt_live && !active_levels_o[1] |-> irq_pending_o)
    else $error("watchdog request masked");
  AST_WDT_CAUSE: assert property (stack_push_o && source_o == 4'h1 |->
    $past(watchdog_irq_select_i) && $past(watchdog_timeout_i) != 4'h0)
    else $error("watchdog entry unarmed");
  AST_SAME_LEVEL: assert property (stack_push_o |-> !$past(active_levels_o[1]))
    else $error("entry while high routine active");
  AST_LOW_BLOCK: assert property (stack_push_o && active_levels_o == 2'b01 |->
    $past(active_levels_o) == 2'b00)
    else $error("low entry while a routine active");
  AST_RETI: assert property (core_reti_i && active_levels_o == 2'b11 |=>
    active_levels_o == 2'b01)
    else $error("high level not dropped");
endmodule // tlic_properties

bind tlic_top tlic_properties u_props
(
  .clk_sys_i, .reset_n_i, .watchdog_irq_flag_i, .watchdog_irq_select_i,
  .watchdog_timeout_i, .core_boundary_i, .core_reti_i, .irq_pending_o,
  .stack_push_o, .vector_load_o, .vector_o, .source_o, .active_levels_o
);

// ==== dv/tlic_core_model.sv ====
/*
  core fetch and stack model: offers boundaries, counts nesting, returns.
  assumes the bench requests returns only after a vector load.
*/
module tlic_core_model
(
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  // bench control
  input  wire logic stall_i,
  input  wire logic ret_i,
  // controller side
  input  wire logic vector_load_i,
  output logic      core_boundary_o,
  output logic      core_reti_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] depth;       // entered routines
  logic [3:0] next_depth;  // depth after this cycle
  logic       back;        // return from an entered routine only
  assign core_boundary_o = !stall_i;
  assign back = ret_i && depth != 4'h0;
  assign next_depth = depth + {3'h0, vector_load_i} - {3'h0, back};
  // nesting count and one cycle return pulse
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      {depth, core_reti_o} <= 5'h00;
    else
      {depth, core_reti_o} <= {next_depth, back};
  end
endmodule // tlic_core_model

// ==== dv/tlic_bench.sv ====
/*
  self-checking bench of the two level interrupt controller.
  assumes the core model and the bound checker are compiled before it.
*/
module tlic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // stimulus, observation and counters
  typedef struct {logic [3:0] fb; logic [15:0] v; logic [3:0] s;} tlic_row_t;
  tlic_row_t rows [14] = '{'{0, 16'h0003, 2}, '{1, 16'h0013, 5}, '{2, 16'h000b, 4},
    '{3, 16'h001b, 6}, '{4, 16'h002b, 9}, '{5, 16'h002b, 9}, '{6, 16'h0023, 8},
    '{7, 16'h0023, 8}, '{8, 16'h0033, 3}, '{9, 16'h0033, 3}, '{10, 16'h003b, 7},
    '{11, 16'h003b, 7}, '{12, 16'h0043, 0}, '{13, 16'h0053, 10}};
  logic        clk_sys_i = 0, reset_n_i = 0, sfr_wr_i = 0, sfr_rd_i = 0, stall = 0, ret = 0;
  logic        watchdog_irq_flag_i = 0, watchdog_irq_select_i = 0;
  logic [3:0]  watchdog_timeout_i = 0, source_o;
  logic [7:0]  sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata_o;
  logic [13:0] fl = 0;
  logic        core_boundary_i, core_reti_i, irq_pending_o, stack_push_o, vector_load_o, hit;
  logic [15:0] vector_o;
  logic [1:0]  active_levels_o;
  int          error_cnt = 0, comparisons = 0, cyc = 0;
  tlic_top uut
  (
    .clk_sys_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i,
    .sfr_hit_o(hit), .sfr_rdata_o, .ext0_request_flag_i(fl[0]), .ext1_request_flag_i(fl[1]),
    .timer0_overflow_flag_i(fl[2]), .timer1_overflow_flag_i(fl[3]),
    .timer2_overflow_flag_i(fl[4]), .timer2_external_flag_i(fl[5]),
    .uart_receive_flag_i(fl[6]), .uart_send_flag_i(fl[7]), .primary_adc_ready_i(fl[8]),
    .aux_adc_ready_i(fl[9]), .spi_irq_flag_i(fl[10]), .two_wire_irq_flag_i(fl[11]),
    .supply_monitor_irq_flag_i(fl[12]), .interval_timer_irq_flag_i(fl[13]),
    .watchdog_irq_flag_i, .watchdog_irq_select_i, .watchdog_timeout_i, .core_boundary_i,
    .core_reti_i, .irq_pending_o, .stack_push_o, .vector_load_o, .vector_o, .source_o,
    .active_levels_o
  );
  tlic_core_model core
  (
    .clk_sys_i, .reset_n_i, .stall_i(stall), .ret_i(ret), .vector_load_i(vector_load_o),
    .core_boundary_o(core_boundary_i), .core_reti_o(core_reti_i)
  );
  always #4 clk_sys_i = ~clk_sys_i;
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    {sfr_addr_i, sfr_wdata_i, sfr_wr_i} <= {a, d, 1'b1};
    @(posedge clk_sys_i);
    sfr_wr_i <= 0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    {sfr_addr_i, sfr_rd_i} <= {a, 1'b1};
    @(posedge clk_sys_i);
    sfr_rd_i <= 0;
    #1 chk({8'h00, sfr_rdata_o}, {8'h00, e});
    chk({15'h0, hit}, {15'h0, a inside {8'ha8, 8'ha9, 8'hb8}});
  endtask
  // wait for entry, check it, then the load
  task automatic take(input logic [15:0] v, input logic [3:0] s, input logic [1:0] lv);
    for (int i = 0; i < 20 && stack_push_o !== 1'b1; i++)
    begin
      @(posedge clk_sys_i);
      #1;
    end
    chk({15'h0, stack_push_o}, 16'h1);
    chk(vector_o, v);
    chk({12'h0, source_o}, {12'h0, s});
    chk({14'h0, active_levels_o}, {14'h0, lv});
    @(posedge clk_sys_i);
    #1 chk({15'h0, vector_load_o}, 16'h1);
  endtask
  // clear flags, return, check levels
  task automatic rti(input logic [13:0] clr, input logic [1:0] lv);
    @(posedge clk_sys_i);
    {fl, ret} <= {fl & ~clr, 1'b1};
    @(posedge clk_sys_i);
    ret <= 0;
    repeat (2) @(posedge clk_sys_i);
    #1 chk({14'h0, active_levels_o}, {14'h0, lv});
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1;
    wr(8'ha8, 8'hff);
    wr(8'ha9, 8'h07);
    foreach (rows[i])
    begin
      @(posedge clk_sys_i);
      fl <= 14'h1 << rows[i].fb;
      take(rows[i].v, rows[i].s, 2'b01);
      rti(14'h3fff, 2'b00);
    end
    $display("vector table done");
    @(posedge clk_sys_i);
    reset_n_i <= 0;
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1;
    rdchk(8'ha8, 8'h00);
    rdchk(8'ha9, 8'ha0);
    rdchk(8'hb8, 8'h00);
    rdchk(8'h5a, 8'h00);
    wr(8'ha9, 8'h77);
    rdchk(8'ha9, 8'h77);
    wr(8'hb8, 8'hff);
    rdchk(8'hb8, 8'h7f);
    $display("register test done");
    wr(8'ha8, 8'h87);
    wr(8'hb8, 8'h04);
    @(posedge clk_sys_i);
    fl <= 14'h0007;
    take(16'h0013, 4'h5, 2'b10);
    rti(14'h0002, 2'b01);
    take(16'h0003, 4'h2, 2'b01);
    chk({15'h0, irq_pending_o}, 16'h0);
    @(posedge clk_sys_i);
    fl[1] <= 1;
    take(16'h0013, 4'h5, 2'b11);
    rti(14'h0002, 2'b01);
    rti(14'h0001, 2'b01);
    take(16'h000b, 4'h4, 2'b01);
    rti(14'h0004, 2'b00);
    $display("level test done");
    wr(8'ha8, 8'h7f);
    @(posedge clk_sys_i);
    {fl, stall, watchdog_irq_flag_i, watchdog_irq_select_i} <= {14'h0001, 3'b111};
    repeat (2) @(posedge clk_sys_i);
    #1 chk({15'h0, irq_pending_o}, 16'h0);
    @(posedge clk_sys_i);
    watchdog_timeout_i <= 4'h5;
    repeat (2) @(posedge clk_sys_i);
    #1 chk({15'h0, irq_pending_o}, 16'h1);
    chk({15'h0, stack_push_o}, 16'h0);
    @(posedge clk_sys_i);
    stall <= 0;
    take(16'h005b, 4'h1, 2'b10);
    @(posedge clk_sys_i);
    watchdog_irq_flag_i <= 0;
    rti(14'h3fff, 2'b00);
    $display("watchdog test done");
    end_sim();
  end
endmodule // tlic_bench
